// ### design/scc_top.sv
// What this block does
// - Bits 11..6: mix A, code A, polarity A
// - Bits 5..0: mix B, code B, polarity B
// - Polarity zero drives out1 to out2
// - Status MSB first, load 11..9, bit8 one
// - Bits 7,6,5: overtemp, prewarn, undervoltage
// - Overcurrent flags after 3 hits; 64 quiet cycles reset the count
// - Open load after 15 cycles without switch-off
// - Code zero holds bridge in slow decay
// - Code scales linearly, fifteen steps to full
// - Reset or disable clears command register
// - Both codes zero clears overcurrent, standby
// - Open load reads zero at code zero
// - Faults also raise open load flags
// - Enable pin low active, high disables
// - Reference select low picks external reference, only in enabled serial mode
// - Serial output is tri-state capable
// - Load indicator refreshed once per full step
// - Disable in serial mode resets serial logic
// - Disable clears all status flags
`timescale 1ns/10ps
`default_nettype none

module scc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic serial_din,
    output logic serial_dout,
    output logic serial_dout_oe,
    // Mode pins
    input wire logic device_enable_n,
    input wire logic serial_mode_select,
    input wire logic ext_ref_select_n,
    // Chopper and analog events
    input wire logic pwm_cycle_start,
    input wire logic osc_cycle,
    input wire logic pwm_switchoff_a,
    input wire logic pwm_switchoff_b,
    input wire logic overcurrent_low_a,
    input wire logic overcurrent_low_b,
    input wire logic overcurrent_high,
    input wire logic over_temp,
    input wire logic heat_prewarn,
    input wire logic supply_low,
    input wire logic [2:0] load_level,
    // Coil settings
    output logic mixdecay_en_a,
    output logic [3:0] coil_a_current_code,
    output logic polarity_a,
    output logic mixdecay_en_b,
    output logic [3:0] coil_b_current_code,
    output logic polarity_b,
    output logic ref_external_a,
    output logic ref_external_b,
    // Bridge drive
    output logic bridge_a_out1,
    output logic bridge_a_out2,
    output logic bridge_b_out1,
    output logic bridge_b_out2,
    output logic chopper_active_a,
    output logic chopper_active_b,
    // Power state
    output logic low_power_standby,
    output logic shutdown
);

    logic rst_meta_q, rst_sync_q;
    logic [scc_pkg::PIN_W-1:0] pin_meta_q, pin_sync_q, pin_prev_q;
    logic [scc_pkg::PIN_W-1:0] pin_raw;
    logic [scc_pkg::PIN_W-1:0] pin_rise;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign pin_raw = {load_level, supply_low, heat_prewarn, over_temp, overcurrent_high,
                      overcurrent_low_b, overcurrent_low_a, pwm_switchoff_b, pwm_switchoff_a,
                      osc_cycle, pwm_cycle_start, ext_ref_select_n, serial_mode_select,
                      device_enable_n, serial_din, chip_select_n, serial_clk};

    // Every pin passes two flops; the third only feeds edge detection
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pin_meta_q <= scc_pkg::PIN_RESET;
            pin_sync_q <= scc_pkg::PIN_RESET;
            pin_prev_q <= scc_pkg::PIN_RESET;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign pin_rise = pin_sync_q & ~pin_prev_q;

    logic disabled;
    logic serial_on;
    logic sck_rise, sck_fall, cs_fall, cs_rise, cs_low;

    assign disabled = pin_sync_q[scc_pkg::PIN_EN_N];
    assign serial_on = pin_sync_q[scc_pkg::PIN_SPE] && !disabled;
    assign sck_rise = pin_rise[scc_pkg::PIN_SCK];
    assign sck_fall = !pin_sync_q[scc_pkg::PIN_SCK] && pin_prev_q[scc_pkg::PIN_SCK];
    assign cs_fall = !pin_sync_q[scc_pkg::PIN_CS_N] && pin_prev_q[scc_pkg::PIN_CS_N];
    assign cs_rise = pin_rise[scc_pkg::PIN_CS_N];
    assign cs_low = !pin_sync_q[scc_pkg::PIN_CS_N];

    // Serial state
    scc_pkg::scc_spi_state_type spi_q, spi_d;
    logic [11:0] rx_q, rx_d;
    logic [11:0] tx_q, tx_d;
    logic [3:0] cnt_q, cnt_d;
    logic [11:0] cmd_q, cmd_d;
    logic [2:0] load_q, load_d;
    logic commit;
    logic [11:0] status_word;

    always_comb begin
        spi_d = spi_q;
        rx_d = rx_q;
        tx_d = tx_q;
        cnt_d = cnt_q;
        cmd_d = cmd_q;
        load_d = load_q;
        commit = 1'b0;
        case (spi_q)
            scc_pkg::SPI_IDLE: begin
                if (cs_fall) begin
                    spi_d = scc_pkg::SPI_ACTIVE;
                    cnt_d = 4'h0;
                    tx_d = status_word;
                end
            end
            scc_pkg::SPI_ACTIVE: begin
                if (cs_rise) begin
                    spi_d = scc_pkg::SPI_IDLE;
                    // Short telegrams are dropped; longer ones keep the last twelve bits
                    commit = cnt_q == scc_pkg::BIT_CNT_FULL;
                end else if (sck_rise) begin
                    rx_d = {rx_q[10:0], pin_sync_q[scc_pkg::PIN_SDI]};
                    if (cnt_q != scc_pkg::BIT_CNT_FULL) begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end else if (sck_fall) begin
                    tx_d = {tx_q[10:0], 1'b0};
                end
            end
            default: begin
                spi_d = scc_pkg::SPI_IDLE;
            end
        endcase
        if (commit) begin
            cmd_d = rx_q;
            // Full step seen as a polarity change on either coil
            if (rx_q[scc_pkg::CMD_POL_A] != cmd_q[scc_pkg::CMD_POL_A] ||
                rx_q[scc_pkg::CMD_POL_B] != cmd_q[scc_pkg::CMD_POL_B]) begin
                load_d = pin_sync_q[scc_pkg::PIN_LOAD_MSB:scc_pkg::PIN_LOAD_LSB];
            end
        end
        if (!serial_on) begin
            spi_d = scc_pkg::SPI_IDLE;
            rx_d = scc_pkg::CMD_RESET;
            tx_d = scc_pkg::CMD_RESET;
            cnt_d = 4'h0;
        end
        if (disabled) begin
            cmd_d = scc_pkg::CMD_RESET;
            load_d = scc_pkg::LOAD_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            spi_q <= scc_pkg::SPI_IDLE;
            rx_q <= scc_pkg::CMD_RESET;
            tx_q <= scc_pkg::CMD_RESET;
            cnt_q <= 4'h0;
            cmd_q <= scc_pkg::CMD_RESET;
            load_q <= scc_pkg::LOAD_RESET;
        end else begin
            spi_q <= spi_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            cnt_q <= cnt_d;
            cmd_q <= cmd_d;
            load_q <= load_d;
        end
    end

    logic [3:0] code_a, code_b;
    logic zero_a, zero_b;
    logic oc_clear;

    assign code_a = cmd_q[scc_pkg::CMD_CODE_A_MSB:scc_pkg::CMD_CODE_A_LSB];
    assign code_b = cmd_q[scc_pkg::CMD_CODE_B_MSB:scc_pkg::CMD_CODE_B_LSB];
    assign zero_a = code_a == scc_pkg::CODE_ZERO;
    assign zero_b = code_b == scc_pkg::CODE_ZERO;
    // Both-zero telegram clears overcurrent; disable clears it as well
    assign oc_clear = disabled || (commit && rx_q[scc_pkg::CMD_CODE_A_MSB:scc_pkg::CMD_CODE_A_LSB] ==
                      scc_pkg::CODE_ZERO && rx_q[scc_pkg::CMD_CODE_B_MSB:scc_pkg::CMD_CODE_B_LSB] ==
                      scc_pkg::CODE_ZERO);

    logic oc_a, oc_b, oc_hs, blk_a, blk_b, blk_hs;

    scc_oc_counter u_oc_a (
        .clk(clk),
        .rst_n(rst_sync_q),
        .clear(oc_clear),
        .pwm_tick(pin_rise[scc_pkg::PIN_PWM]),
        .oc_hit(pin_rise[scc_pkg::PIN_OC_A]),
        .flag(oc_a),
        .block(blk_a)
    );

    scc_oc_counter u_oc_b (
        .clk(clk),
        .rst_n(rst_sync_q),
        .clear(oc_clear),
        .pwm_tick(pin_rise[scc_pkg::PIN_PWM]),
        .oc_hit(pin_rise[scc_pkg::PIN_OC_B]),
        .flag(oc_b),
        .block(blk_b)
    );

    scc_oc_counter u_oc_hs (
        .clk(clk),
        .rst_n(rst_sync_q),
        .clear(oc_clear),
        .pwm_tick(pin_rise[scc_pkg::PIN_PWM]),
        .oc_hit(pin_rise[scc_pkg::PIN_OC_HS]),
        .flag(oc_hs),
        .block(blk_hs)
    );

    // Open load watch per bridge
    logic [3:0] ol_cnt_a_q, ol_cnt_a_d, ol_cnt_b_q, ol_cnt_b_d;
    logic ol_a, ol_b, fault_any;
    logic ot, heat_prewarn_flag, uv;

    assign ot = pin_sync_q[scc_pkg::PIN_OT] && !disabled;
    assign heat_prewarn_flag = pin_sync_q[scc_pkg::PIN_HEAT_PREWARN_FLAG] && !disabled;
    assign uv = pin_sync_q[scc_pkg::PIN_UV] && !disabled;

    always_comb begin
        ol_cnt_a_d = ol_cnt_a_q;
        ol_cnt_b_d = ol_cnt_b_q;
        if (pin_rise[scc_pkg::PIN_OFF_A] || zero_a || disabled) begin
            ol_cnt_a_d = 4'h0;
        end else if (pin_rise[scc_pkg::PIN_OSC] && ol_cnt_a_q != scc_pkg::OPEN_LOAD_SAT) begin
            ol_cnt_a_d = ol_cnt_a_q + 4'h1;
        end
        if (pin_rise[scc_pkg::PIN_OFF_B] || zero_b || disabled) begin
            ol_cnt_b_d = 4'h0;
        end else if (pin_rise[scc_pkg::PIN_OSC] && ol_cnt_b_q != scc_pkg::OPEN_LOAD_SAT) begin
            ol_cnt_b_d = ol_cnt_b_q + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ol_cnt_a_q <= 4'h0;
            ol_cnt_b_q <= 4'h0;
        end else begin
            ol_cnt_a_q <= ol_cnt_a_d;
            ol_cnt_b_q <= ol_cnt_b_d;
        end
    end

    // Faults stop switching, so they show as open load too
    assign fault_any = oc_a || oc_b || oc_hs || uv || ot;
    // Zero code wins: with no chopping there is nothing to judge
    assign ol_a = !zero_a && !disabled && (ol_cnt_a_q > scc_pkg::OPEN_LOAD_LIMIT || fault_any);
    assign ol_b = !zero_b && !disabled && (ol_cnt_b_q > scc_pkg::OPEN_LOAD_LIMIT || fault_any);

    always_comb begin
        status_word = 12'h000;
        status_word[scc_pkg::ST_LOAD_MSB:scc_pkg::ST_LOAD_LSB] = load_q;
        status_word[scc_pkg::ST_ONE] = 1'b1;
        status_word[scc_pkg::ST_OVER_TEMP] = ot;
        status_word[scc_pkg::ST_PREWARN] = heat_prewarn_flag;
        status_word[scc_pkg::ST_SUPPLY_LOW] = uv;
        status_word[scc_pkg::ST_OC_HIGH] = oc_hs;
        status_word[scc_pkg::ST_OPEN_B] = ol_b;
        status_word[scc_pkg::ST_OPEN_A] = ol_a;
        status_word[scc_pkg::ST_OC_B] = oc_b;
        status_word[scc_pkg::ST_OC_A] = oc_a;
    end

    // Bridge drive, registered
    logic chop_a_q, chop_a_d, chop_b_q, chop_b_d;
    logic a1_q, a1_d, a2_q, a2_d, b1_q, b1_d, b2_q, b2_d;
    logic stop_all;

    // Undervoltage and overtemperature stop both bridges
    assign stop_all = disabled || ot || uv || blk_hs;

    always_comb begin
        chop_a_d = !zero_a && !stop_all && !blk_a;
        chop_b_d = !zero_b && !stop_all && !blk_b;
        // Idle bridge rests with both high sides off, i.e. slow decay
        a1_d = chop_a_d && !cmd_q[scc_pkg::CMD_POL_A];
        a2_d = chop_a_d && cmd_q[scc_pkg::CMD_POL_A];
        b1_d = chop_b_d && !cmd_q[scc_pkg::CMD_POL_B];
        b2_d = chop_b_d && cmd_q[scc_pkg::CMD_POL_B];
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            chop_a_q <= 1'b0;
            chop_b_q <= 1'b0;
            a1_q <= 1'b0;
            a2_q <= 1'b0;
            b1_q <= 1'b0;
            b2_q <= 1'b0;
        end else begin
            chop_a_q <= chop_a_d;
            chop_b_q <= chop_b_d;
            a1_q <= a1_d;
            a2_q <= a2_d;
            b1_q <= b1_d;
            b2_q <= b2_d;
        end
    end

    assign mixdecay_en_a = cmd_q[scc_pkg::CMD_MIX_A];
    assign coil_a_current_code = code_a;
    assign polarity_a = cmd_q[scc_pkg::CMD_POL_A];
    assign mixdecay_en_b = cmd_q[scc_pkg::CMD_MIX_B];
    assign coil_b_current_code = code_b;
    assign polarity_b = cmd_q[scc_pkg::CMD_POL_B];
    // Only meaningful in serial mode; stand-alone uses the inputs directly
    assign ref_external_a = !pin_sync_q[scc_pkg::PIN_REF_N] && serial_on;
    assign ref_external_b = !pin_sync_q[scc_pkg::PIN_REF_N] && serial_on;
    assign bridge_a_out1 = a1_q;
    assign bridge_a_out2 = a2_q;
    assign bridge_b_out1 = b1_q;
    assign bridge_b_out2 = b2_q;
    assign chopper_active_a = chop_a_q;
    assign chopper_active_b = chop_b_q;
    assign low_power_standby = zero_a && zero_b;
    assign shutdown = disabled && pin_sync_q[scc_pkg::PIN_SPE];
    assign serial_dout = tx_q[scc_pkg::WORD_W-1];
    assign serial_dout_oe = cs_low && serial_on && spi_q == scc_pkg::SPI_ACTIVE;

endmodule

`default_nettype wire

// ### shared/scc_pkg.sv
`default_nettype none

package scc_pkg;

    // Telegram geometry
    localparam int WORD_W = 12;
    localparam logic [3:0] BIT_CNT_FULL = 4'hC;

    // Command word fields
    localparam int CMD_MIX_A = 11;
    localparam int CMD_CODE_A_MSB = 10;
    localparam int CMD_CODE_A_LSB = 7;
    localparam int CMD_POL_A = 6;
    localparam int CMD_MIX_B = 5;
    localparam int CMD_CODE_B_MSB = 4;
    localparam int CMD_CODE_B_LSB = 1;
    localparam int CMD_POL_B = 0;
    localparam logic [11:0] CMD_RESET = 12'h000;

    // Status word fields
    localparam int ST_LOAD_MSB = 11;
    localparam int ST_LOAD_LSB = 9;
    localparam int ST_ONE = 8;
    localparam int ST_OVER_TEMP = 7;
    localparam int ST_PREWARN = 6;
    localparam int ST_SUPPLY_LOW = 5;
    localparam int ST_OC_HIGH = 4;
    localparam int ST_OPEN_B = 3;
    localparam int ST_OPEN_A = 2;
    localparam int ST_OC_B = 1;
    localparam int ST_OC_A = 0;
    localparam logic [2:0] LOAD_RESET = 3'h0;

    // Current code scale
    localparam logic [3:0] CODE_ZERO = 4'h0;
    localparam logic [3:0] CODE_FULL = 4'hF;
    localparam int FULL_SCALE_MV = 340;

    // Fault timing in chopper and oscillator cycles
    localparam logic [1:0] OC_EVENTS = 2'h3;
    localparam logic [5:0] OC_WINDOW = 6'h3F;
    localparam logic [6:0] OC_QUIET_LIMIT = 7'h40;
    localparam logic [3:0] OPEN_LOAD_LIMIT = 4'hE;
    localparam logic [3:0] OPEN_LOAD_SAT = 4'hF;

    // Pin sampling vector positions
    localparam int PIN_W = 19;
    localparam int PIN_SCK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_EN_N = 3;
    localparam int PIN_SPE = 4;
    localparam int PIN_REF_N = 5;
    localparam int PIN_PWM = 6;
    localparam int PIN_OSC = 7;
    localparam int PIN_OFF_A = 8;
    localparam int PIN_OFF_B = 9;
    localparam int PIN_OC_A = 10;
    localparam int PIN_OC_B = 11;
    localparam int PIN_OC_HS = 12;
    localparam int PIN_OT = 13;
    localparam int PIN_HEAT_PREWARN_FLAG = 14;
    localparam int PIN_UV = 15;
    localparam int PIN_LOAD_LSB = 16;
    localparam int PIN_LOAD_MSB = 18;
    localparam logic [18:0] PIN_RESET = 19'h0000A;

    typedef enum logic [0:0] {
        SPI_IDLE = 1'b0,
        SPI_ACTIVE = 1'b1
    } scc_spi_state_type;

endpackage

`default_nettype wire

// ### design/scc_oc_counter.sv
`timescale 1ns/10ps
`default_nettype none

module scc_oc_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Events
    input wire logic clear,
    input wire logic pwm_tick,
    input wire logic oc_hit,
    // Result
    output logic flag,
    output logic block
);

    logic [1:0] err_q, err_d;
    logic [6:0] quiet_q, quiet_d;
    logic [5:0] block_q, block_d;
    logic flag_q, flag_d;
    logic set;

    always_comb begin
        err_d = err_q;
        quiet_d = quiet_q;
        block_d = block_q;
        set = 1'b0;
        if (pwm_tick && block_q != 6'h00) begin
            block_d = block_q - 6'h01;
        end
        if (oc_hit) begin
            quiet_d = 7'h00;
            if (err_q + 2'h1 == scc_pkg::OC_EVENTS) begin
                set = 1'b1;
                err_d = 2'h0;
                block_d = scc_pkg::OC_WINDOW;
            end else begin
                err_d = err_q + 2'h1;
            end
        end else if (pwm_tick) begin
            // Error count forgets once the quiet window is complete, not one tick later
            if (quiet_q != scc_pkg::OC_QUIET_LIMIT) begin
                quiet_d = quiet_q + 7'h01;
            end
            if (quiet_d == scc_pkg::OC_QUIET_LIMIT) begin
                err_d = 2'h0;
            end
        end
        if (clear && !set) begin
            err_d = 2'h0;
            block_d = 6'h00;
        end
        // Set wins over a clear in the same cycle
        flag_d = (flag_q && !clear) || set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 2'h0;
            quiet_q <= 7'h00;
            block_q <= 6'h00;
            flag_q <= 1'b0;
        end else begin
            err_q <= err_d;
            quiet_q <= quiet_d;
            block_q <= block_d;
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
    assign block = block_q != 6'h00;

endmodule

`default_nettype wire

// ### bench/scc_top_props.sv
`timescale 1ns/10ps
`default_nettype none

module scc_top_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode and select pins
    input wire logic chip_select_n,
    input wire logic device_enable_n,
    input wire logic serial_mode_select,
    input wire logic ext_ref_select_n,
    // Observed outputs
    input wire logic serial_dout_oe,
    input wire logic mixdecay_en_a,
    input wire logic [3:0] coil_a_current_code,
    input wire logic polarity_a,
    input wire logic [3:0] coil_b_current_code,
    input wire logic bridge_a_out1,
    input wire logic bridge_a_out2,
    input wire logic chopper_active_a,
    input wire logic ref_external_a,
    input wire logic ref_external_b,
    input wire logic low_power_standby,
    input wire logic shutdown
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_oe_deselect: assert property (
        chip_select_n [*5] |-> !serial_dout_oe) else $error("serial output driven while deselected");
    chk_oe_standalone: assert property (
        !serial_mode_select [*5] |-> !serial_dout_oe) else $error("serial output driven in stand-alone mode");
    chk_disable_clear: assert property (
        device_enable_n [*6] |-> {mixdecay_en_a, coil_a_current_code, polarity_a, coil_b_current_code} == 10'h000)
        else $error("command not cleared while disabled");
    chk_shutdown_pin: assert property (
        $stable({device_enable_n, serial_mode_select}) [*8] |-> shutdown == (device_enable_n && serial_mode_select))
        else $error("shutdown does not follow enable pin");
    chk_ref_select: assert property (
        (serial_mode_select && $stable(ext_ref_select_n)) [*6] |-> {ref_external_a, ref_external_b} == {2{!ext_ref_select_n}})
        else $error("reference select not applied");
    chk_standby_zero: assert property (
        low_power_standby [*2] |-> !chopper_active_a && !bridge_a_out1 && !bridge_a_out2 && coil_b_current_code == 4'h0)
        else $error("coil active in standby");
    chk_zero_slow: assert property (
        (coil_a_current_code == 4'h0) [*3] |-> !bridge_a_out1 && !bridge_a_out2 && !chopper_active_a)
        else $error("bridge active with zero code");
    chk_polarity_dir: assert property (
        (coil_a_current_code != 4'h0 && $stable(polarity_a)) [*3] |-> !(polarity_a ? bridge_a_out1 : bridge_a_out2))
        else $error("bridge driven against polarity");
    chk_commit_deselect: assert property (
        ($changed({mixdecay_en_a, coil_a_current_code, polarity_a, coil_b_current_code})
        && {mixdecay_en_a, coil_a_current_code, polarity_a, coil_b_current_code} != 10'h000) |-> $past(chip_select_n, 3))
        else $error("command changed without deselect");

    cov_frame: cover property (chip_select_n ##1 !chip_select_n ##[1:8] serial_dout_oe);
    cov_shutdown: cover property ($rose(shutdown));
    cov_wake: cover property ($fell(low_power_standby));
    cov_ext_ref: cover property (ref_external_a && serial_dout_oe);
endmodule

bind scc_top scc_top_props u_props (.*);

`default_nettype wire

// ### bench/scc_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module scc_ctrl_model (
    // Clock
    input wire logic clk,
    // Serial link
    output logic serial_clk,
    output logic chip_select_n,
    output logic serial_din,
    input wire logic serial_dout,
    input wire logic serial_dout_oe
);
    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b1;
        serial_din = 1'b1;
    end

    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // One whole telegram per call; link clock idles low between frames
    task automatic xfer(input logic [11:0] cmd, output logic [11:0] sts);
        @(posedge clk);
        #1;
        chip_select_n = 1'b0;
        for (int i = 11; i >= 0; i--) begin
            serial_din = cmd[i];
            half();
            serial_clk = 1'b1;
            sts[i] = serial_dout_oe ? serial_dout : 1'bz;
            half();
            serial_clk = 1'b0;
        end
        half();
        chip_select_n = 1'b1;
        // Released line must not keep its last value
        serial_din = ~serial_din;
    endtask
endmodule

`default_nettype wire

// ### bench/scc_top_test.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
end

module scc_top_test;
    logic clk, rst_n, serial_clk, chip_select_n, serial_din, serial_dout, serial_dout_oe;
    logic device_enable_n, serial_mode_select, ext_ref_select_n, pwm_cycle_start, osc_cycle;
    logic pwm_switchoff_a, pwm_switchoff_b, overcurrent_low_a, overcurrent_low_b, overcurrent_high;
    logic over_temp, heat_prewarn, supply_low, mixdecay_en_a, polarity_a, mixdecay_en_b, polarity_b;
    logic [2:0] load_level;
    logic [3:0] coil_a_current_code, coil_b_current_code;
    logic ref_external_a, ref_external_b, bridge_a_out1, bridge_a_out2, bridge_b_out1, bridge_b_out2;
    logic chopper_active_a, chopper_active_b, low_power_standby, shutdown;
    logic [6:0] ev = 7'h00;
    logic [11:0] prev = 12'h000;
    logic [2:0] ld = 3'h0;
    integer seed = 32'hA0A68675;
    int fails = 0;
    int comparisons = 0;

    assign {pwm_cycle_start, osc_cycle, pwm_switchoff_b, pwm_switchoff_a, overcurrent_high, overcurrent_low_b,
        overcurrent_low_a} = ev;

    scc_top u_dut (.*);
    scc_ctrl_model u_ctrl (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Pulses wide enough to pass the pin synchronisers
    task automatic pulse(input logic [6:0] m, input int n);
        repeat (n) begin
            ev = m;
            tick(3);
            ev = 7'h00;
            tick(3);
        end
    endtask

    task automatic send(input logic [11:0] cmd, input logic [2:0] oc, input logic [1:0] olr, input bit br);
        logic [11:0] st;
        logic f;
        logic [11:0] e;
        f = (|oc) | over_temp | supply_low;
        e = {ld, 1'b1, over_temp, heat_prewarn, supply_low, oc[2], (prev[4:1] != 4'h0) & (olr[1] | f),
            (prev[10:7] != 4'h0) & (olr[0] | f), oc[1:0]};
        u_ctrl.xfer(cmd, st);
        `CHK("status", e, st)
        if ({cmd[6], cmd[0]} != {prev[6], prev[0]}) ld = load_level;
        prev = cmd;
        tick(6);
        `CHK("cmd_a", cmd[11:6], {mixdecay_en_a, coil_a_current_code, polarity_a})
        `CHK("cmd_b", cmd[5:0], {mixdecay_en_b, coil_b_current_code, polarity_b})
        `CHK("standby", cmd[10:7] == 4'h0 && cmd[4:1] == 4'h0, low_power_standby)
        if (br) begin
            `CHK("bridge_a", (cmd[10:7] == 4'h0) ? 3'h0 : {~cmd[6], cmd[6], 1'b1}, {bridge_a_out1, bridge_a_out2, chopper_active_a})
            `CHK("bridge_b", (cmd[4:1] == 4'h0) ? 3'h0 : {~cmd[0], cmd[0], 1'b1}, {bridge_b_out1, bridge_b_out2, chopper_active_b})
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end

    initial begin
        logic [11:0] st;
        logic [2:0] m;
        logic [11:0] corner [3];
        corner = '{12'hFFF, 12'h041, 12'h820};
        {rst_n, device_enable_n, over_temp, heat_prewarn, supply_low} = 5'h00;
        {serial_mode_select, ext_ref_select_n} = 2'h3;
        load_level = 3'h0;
        tick(20);
        rst_n = 1'b1;
        tick(8);
        `CHK("rst_cmd", 12'h000, {mixdecay_en_a, coil_a_current_code, polarity_a, mixdecay_en_b, coil_b_current_code, polarity_b})
        `CHK("rst_oe", 1'b0, serial_dout_oe)
        `CHK("ref_int", 2'h0, {ref_external_a, ref_external_b})
        ext_ref_select_n = 1'b0;
        tick(5);
        `CHK("ref_ext", 2'h3, {ref_external_a, ref_external_b})
        ext_ref_select_n = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            {over_temp, heat_prewarn, supply_low} = (i < 3) ? 3'h0 : 3'($random(seed));
            load_level = 3'($random(seed));
            send((i < 3) ? corner[i] : 12'($random(seed)), 3'h0, 2'h0, !over_temp && !supply_low);
        end
        {over_temp, heat_prewarn, supply_low} = 3'h0;
        $display("test random commands done");
        for (int s = 0; s < 3; s++) begin
            m = 3'h1 << s;
            send(12'h3DE, 3'h0, 2'h0, 1'b0);
            repeat (2) begin
                pulse({4'h0, m}, 1);
                pulse(7'h40, 1);
            end
            send(12'h3DE, 3'h0, 2'h0, 1'b0);
            pulse({4'h0, m}, 1);
            pulse(7'h40, 1);
            send(12'h3DE, m, 2'h0, 1'b0);
            if (s < 2) begin
                send(12'h000, m, 2'h0, 1'b0);
            end else begin
                device_enable_n = 1'b1;
                tick(10);
                `CHK("dis_cmd", 8'h00, {coil_a_current_code, coil_b_current_code})
                `CHK("dis_shut", 1'b1, shutdown)
                device_enable_n = 1'b0;
                tick(8);
                {ld, prev} = 15'h0000;
            end
            send(12'h000, 3'h0, 2'h0, 1'b0);
        end
        $display("test overcurrent done");
        send(12'h3DE, 3'h0, 2'h0, 1'b0);
        pulse(7'h18, 1);
        pulse(7'h20, 14);
        send(12'h3DE, 3'h0, 2'h0, 1'b0);
        pulse(7'h20, 1);
        send(12'h01E, 3'h0, 2'h3, 1'b0);
        send(12'h01E, 3'h0, 2'h3, 1'b0);
        $display("test open load done");
        serial_mode_select = 1'b0;
        tick(4);
        u_ctrl.xfer(12'hFFF, st);
        `CHK("sts_off", 12'hZZZ, st)
        tick(6);
        `CHK("cmd_off", prev[10:7], coil_a_current_code)
        serial_mode_select = 1'b1;
        tick(4);
        send(12'h000, 3'h0, 2'h3, 1'b0);
        $display("test stand-alone done");
        complete_run();
    end
endmodule

`undef CHK
`default_nettype wire
